// [afc_rate_pkg.sv]
// constants for the frequency correction and transmit rate block
package afc_rate_pkg;
  localparam logic [6:0] limit_addr = 7'h2A;
  localparam logic [6:0] afc_read_addr = 7'h2B;
  localparam logic [6:0] rate_scale_addr = 7'h70;
  localparam logic [6:0] modctl_addr = 7'h71;
  localparam logic [6:0] offset_low_addr = 7'h73;
  localparam logic [6:0] offset_high_addr = 7'h74;
  localparam logic [6:0] divider_high_addr = 7'h6E;
  localparam logic [6:0] divider_low_addr = 7'h6F;
  localparam logic [6:0] afc_ctl_addr = 7'h1D;
  localparam logic [6:0] mpk_addr = 7'h08;
  localparam int afc_enable_bit = 6;
  localparam int gear_lsb = 3;
  localparam int wait_lsb = 0;
  localparam int mpk_bit = 4;
  localparam int scale_bit = 5;
  localparam logic [7:0] divider_high_reset = 8'h0A;
  localparam logic [7:0] divider_low_reset = 8'h3D;
  localparam logic [7:0] afc_ctl_reset = 8'h41;
  localparam logic [7:0] limit_reset = 8'h20;
  localparam int ref_hz = 1000000;
  localparam int clk_hz = 125000000;
  // phase accumulator: rate = div * ref / 2^(16+5*scale)
  localparam int phase_bits = 21;
  localparam logic [31:0] ref_cycles = 32'(clk_hz / ref_hz);
  localparam logic [1:0] mod_carrier = 2'h0;
  localparam logic [1:0] mod_ook = 2'h1;
  localparam logic [1:0] mod_fsk = 2'h2;
  localparam logic [1:0] mod_gfsk = 2'h3;
  typedef enum logic [1:0] {st_idle, st_measure, st_settle, st_frozen}
    afc_state_t;
endpackage : afc_rate_pkg

// [afc_datarate_modulation_ctrl.sv]
// frequency correction loop, transmit bit clock and modulation selection
// How it works
// R01: after preamble detect the correction freezes until the packet ends.
// R02: in multi-packet receive the loop is cleared at every packet end.
// R03: feedback equals the measured error at gear zero, halved per step.
// R04: each cycle measures over two bits, corrects, then settles.
// R05: cycle length follows the wait field; one gives four bits.
// R06: wait field zero produces no correction output.
// R07: the pull-in range is clamped by the unsigned limit register.
// R08: the current correction is readable at address 2Bh.
// R09: loop output used only in receive with loop on; else manual offset.
// R10: bit rate equals divider times 1 MHz over 2^(16+5*scale).
// R11: host sets scale bit below 30 kbps, clears it above.
// R12: rate divider is used only when transmitting.
// R13: host reprograms register 58h to C0h above 100 kbps.
// R14: modulation field picks carrier, on-off, shift keying or gaussian.
// R15: host enables the data clock for gaussian keying in direct mode.
// R16: loop and manual offset share one correction register.
// R17: with multi-packet set, receive is held after a valid packet.
// R18: each receive entry restarts the loop at zero, unfrozen.
`timescale 1ns/1ns
module afc_datarate_modulation_ctrl #(
  parameter int err_width = 10
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic rx_bit_tick,
  input wire logic preamble_det,
  input wire logic packet_end,
  input wire logic signed [err_width-1:0] freq_error,
  output logic signed [9:0] synth_correction,
  output logic stay_in_rx,
  output logic tx_bit_clk,
  output logic [1:0] mod_type,
  output logic mod_ook_en,
  output logic mod_fsk_en,
  output logic mod_gauss_en
);
  // ==========================================================
  // reset release
  logic rst_a;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end

  // ==========================================================
  // registers
  logic [7:0] div_hi, div_lo, afc_ctl, limit, scale_reg, modctl, mpk_reg;
  logic [7:0] off_lo;
  logic [1:0] off_hi;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      div_hi <= afc_rate_pkg::divider_high_reset;
      div_lo <= afc_rate_pkg::divider_low_reset;
      afc_ctl <= afc_rate_pkg::afc_ctl_reset;
      limit <= afc_rate_pkg::limit_reset;
      scale_reg <= 8'h00;
      modctl <= 8'h00;
      mpk_reg <= 8'h00;
      off_lo <= 8'h00;
      off_hi <= 2'h0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        afc_rate_pkg::divider_high_addr: div_hi <= reg_wdata;
        afc_rate_pkg::divider_low_addr: div_lo <= reg_wdata;
        afc_rate_pkg::afc_ctl_addr: afc_ctl <= reg_wdata;
        afc_rate_pkg::limit_addr: limit <= reg_wdata;
        afc_rate_pkg::rate_scale_addr: scale_reg <= reg_wdata;
        afc_rate_pkg::modctl_addr: modctl <= reg_wdata;
        afc_rate_pkg::mpk_addr: mpk_reg <= reg_wdata;
        afc_rate_pkg::offset_low_addr: off_lo <= reg_wdata;
        afc_rate_pkg::offset_high_addr: off_hi <= reg_wdata[1:0];
        default: ;
      endcase
    end

  wire afc_en = afc_ctl[afc_rate_pkg::afc_enable_bit];
  wire [2:0] gear = afc_ctl[afc_rate_pkg::gear_lsb +: 3];
  wire [2:0] wait_field = afc_ctl[afc_rate_pkg::wait_lsb +: 3];
  wire multi_pkt = mpk_reg[afc_rate_pkg::mpk_bit];
  wire rate_scale = scale_reg[afc_rate_pkg::scale_bit];
  wire [15:0] divider = {div_hi, div_lo};
  wire signed [9:0] manual_offset_value = {off_hi, off_lo};

  // ==========================================================
  // correction loop
  afc_rate_pkg::afc_state_t state;
  logic [3:0] bit_count;
  logic signed [9:0] auto_freq_correction;
  logic rx_seen;
  wire rx_entry = rx_on && !rx_seen;
  // settle time grows with the wait field; 1 gives two settle bits
  wire [3:0] settle_bits = {wait_field, 1'b0};
  wire signed [10:0] step = 11'(freq_error >>> gear); // R03
  wire signed [10:0] raw = 11'(auto_freq_correction) + step;
  wire signed [10:0] lim = {3'b000, limit};
  wire signed [9:0] clamped = raw > lim ? 10'(lim) :
    (raw < -lim ? 10'(-lim) : 10'(raw)); // R07
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      state <= afc_rate_pkg::st_idle;
      bit_count <= 4'h0;
      auto_freq_correction <= 10'sh000;
      rx_seen <= 1'b0;
    end
    else
    begin
      rx_seen <= rx_on;
      if (!rx_on || rx_entry || !afc_en)
      begin
        state <= afc_rate_pkg::st_measure; // R18
        bit_count <= 4'h0;
        auto_freq_correction <= 10'sh000;
      end
      else if (packet_end && multi_pkt)
      begin
        state <= afc_rate_pkg::st_measure; // R02
        bit_count <= 4'h0;
        auto_freq_correction <= 10'sh000;
      end
      else if (packet_end)
        state <= afc_rate_pkg::st_idle;
      else if (preamble_det && state != afc_rate_pkg::st_idle)
        state <= afc_rate_pkg::st_frozen; // R01
      else if (rx_bit_tick)
      begin
        unique case (state)
          afc_rate_pkg::st_measure:
            if (bit_count == 4'h1)
            begin
              bit_count <= 4'h0; // R04
              if (wait_field != 3'h0) // R06
                auto_freq_correction <= clamped;
              state <= afc_rate_pkg::st_settle;
            end
            else
              bit_count <= bit_count + 4'h1;
          afc_rate_pkg::st_settle:
            if (bit_count + 4'h1 >= settle_bits) // R05
            begin
              bit_count <= 4'h0;
              state <= afc_rate_pkg::st_measure;
            end
            else
              bit_count <= bit_count + 4'h1;
          afc_rate_pkg::st_idle, afc_rate_pkg::st_frozen: ;
        endcase
      end
    end

  // ==========================================================
  // outputs
  // transmit always takes the manual offset, even if receive is also on
  wire use_auto = rx_on && !tx_on && afc_en;
  wire signed [9:0] next_correction = use_auto ?
    auto_freq_correction : manual_offset_value; // R09 R16
  wire [1:0] next_mod = modctl[1:0];
  logic [7:0] next_rdata;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      synth_correction <= 10'sh000;
      mod_type <= 2'h0;
      mod_ook_en <= 1'b0;
      mod_fsk_en <= 1'b0;
      mod_gauss_en <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      synth_correction <= next_correction;
      mod_type <= next_mod;
      mod_ook_en <= next_mod == afc_rate_pkg::mod_ook; // R14
      mod_fsk_en <= next_mod == afc_rate_pkg::mod_fsk ||
        next_mod == afc_rate_pkg::mod_gfsk;
      mod_gauss_en <= next_mod == afc_rate_pkg::mod_gfsk;
      reg_rdata <= next_rdata;
    end
  assign stay_in_rx = rx_on && multi_pkt; // R17

  always_comb
    unique case (reg_addr)
      afc_rate_pkg::afc_read_addr:
        next_rdata = auto_freq_correction[9:2]; // R08
      afc_rate_pkg::divider_high_addr: next_rdata = div_hi;
      afc_rate_pkg::divider_low_addr: next_rdata = div_lo;
      afc_rate_pkg::afc_ctl_addr: next_rdata = afc_ctl;
      afc_rate_pkg::limit_addr: next_rdata = limit;
      afc_rate_pkg::rate_scale_addr: next_rdata = scale_reg;
      afc_rate_pkg::modctl_addr: next_rdata = modctl;
      afc_rate_pkg::mpk_addr: next_rdata = mpk_reg;
      afc_rate_pkg::offset_low_addr: next_rdata = off_lo;
      afc_rate_pkg::offset_high_addr: next_rdata = {6'h00, off_hi};
      default: next_rdata = 8'h00;
    endcase

  // ==========================================================
  // transmit bit clock
  logic [31:0] ref_count;
  logic [afc_rate_pkg::phase_bits-1:0] phase;
  wire ref_tick = ref_count == afc_rate_pkg::ref_cycles - 32'd1;
  // scale drops the rate by 2^5 by adding to lower accumulator bits
  wire [afc_rate_pkg::phase_bits-1:0] inc = rate_scale ?
    afc_rate_pkg::phase_bits'(divider) :
    afc_rate_pkg::phase_bits'({divider, 5'h00});
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      ref_count <= 32'd0;
      phase <= '0;
      tx_bit_clk <= 1'b0;
    end
    else if (!tx_on) // R12
    begin
      ref_count <= 32'd0;
      phase <= '0;
      tx_bit_clk <= 1'b0;
    end
    else
    begin
      ref_count <= ref_tick ? 32'd0 : ref_count + 32'd1;
      if (ref_tick)
        phase <= phase + inc; // R10
      tx_bit_clk <= phase[afc_rate_pkg::phase_bits-1];
    end
endmodule : afc_datarate_modulation_ctrl

// [afc_rate_monitor.sv]
// checker for the correction, rate and modulation block
`timescale 1ns/1ns
module afc_rate_monitor (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic preamble_det,
  input wire logic packet_end,
  input wire logic signed [9:0] synth_correction,
  input wire logic stay_in_rx,
  input wire logic tx_bit_clk,
  input wire logic [1:0] mod_type,
  input wire logic mod_ook_en,
  input wire logic mod_fsk_en,
  input wire logic mod_gauss_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ====================
  // sequences and checks
  sequence s_freeze;
    rx_on && preamble_det ##1 (rx_on && !packet_end)[*2];
  endsequence
  sequence s_off_wr;
    reg_wr && reg_addr == afc_rate_pkg::offset_low_addr && tx_on ##1 tx_on;
  endsequence
  AST_FREEZE: assert property (s_freeze |-> $stable(synth_correction))
    else $error("correction moved after preamble");
  AST_TX_OFFSET: assert property (s_off_wr |=>
    synth_correction[7:0] == $past(reg_wdata, 2))
    else $error("offset not applied in transmit");
  AST_STAY: assert property (stay_in_rx |-> rx_on)
    else $error("stay without receive");
  AST_TXCLK_OFF: assert property (!tx_on ##1 !tx_on |-> !tx_bit_clk)
    else $error("bit clock outside transmit");
  AST_OOK: assert property (mod_ook_en == (mod_type == 2'h1))
    else $error("on-off enable wrong");
  AST_FSK: assert property (mod_fsk_en == mod_type[1])
    else $error("shift keying enable wrong");
  AST_GAUSS: assert property (mod_gauss_en == (mod_type == 2'h3))
    else $error("gaussian enable wrong");
  AST_UNMAPPED: assert property (reg_addr == 7'h7F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_READBACK: assert property (reg_wr && reg_addr == 7'h6E ##1
    reg_addr == 7'h6E |=> reg_rdata == $past(reg_wdata, 2))
    else $error("divider readback wrong");
endmodule : afc_rate_monitor
bind afc_datarate_modulation_ctrl afc_rate_monitor u_afc_rate_monitor (
  .mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_on(rx_on),
  .tx_on(tx_on), .preamble_det(preamble_det), .packet_end(packet_end),
  .synth_correction(synth_correction), .stay_in_rx(stay_in_rx),
  .tx_bit_clk(tx_bit_clk), .mod_type(mod_type), .mod_ook_en(mod_ook_en),
  .mod_fsk_en(mod_fsk_en), .mod_gauss_en(mod_gauss_en));

// [afc_air_model.sv]
// remote sender: bit ticks, carrier error and packet markers
`timescale 1ns/1ns
module afc_air_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic signed [9:0] err,
  output logic tick,
  output logic pre,
  output logic pend,
  output logic signed [9:0] ferr
);
  logic [8:0] cyc = 9'h000;
  logic act = 1'b0;
  // one bit every 8 cycles, preamble at bit 21, end at bit 40
  assign tick = act && cyc[2:0] == 3'h7;
  assign pre = act && cyc == 9'h0A7;
  assign pend = act && cyc == 9'h13F;
  always @(posedge mclk)
  begin
    act <= go || (act && !pend);
    cyc <= act ? cyc + 9'h001 : 9'h000;
    // no signal: the error reading toggles instead of holding
    ferr <= act ? err : ~ferr;
  end
endmodule : afc_air_model

// [tb.sv]
// testbench for the correction, rate and modulation block
`timescale 1ns/1ns
module tb;
  logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, rx_on = 1'b0;
  logic tx_on = 1'b0, go = 1'b0, tick, pre, pend, stay_in_rx, tx_bit_clk;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic signed [9:0] ferr, synth_correction, held;
  logic [1:0] mod_type;
  logic mod_ook_en, mod_fsk_en, mod_gauss_en;
  int num_errors = 0, check_count = 0, n;
  afc_datarate_modulation_ctrl u_afc_datarate_modulation_ctrl (
    .mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_on(rx_on),
    .tx_on(tx_on), .rx_bit_tick(tick), .preamble_det(pre),
    .packet_end(pend), .freq_error(ferr),
    .synth_correction(synth_correction), .stay_in_rx(stay_in_rx),
    .tx_bit_clk(tx_bit_clk), .mod_type(mod_type), .mod_ook_en(mod_ook_en),
    .mod_fsk_en(mod_fsk_en), .mod_gauss_en(mod_gauss_en));
  afc_air_model u_afc_air_model (.mclk(mclk), .go(go), .err(10'h010),
    .tick(tick), .pre(pre), .pend(pend), .ferr(ferr));
  // ====================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask : rdc
  task automatic period(input int e);
    time t0;
    repeat (2) @(posedge tx_bit_clk);
    t0 = $time;
    @(posedge tx_bit_clk);
    chk(16'(($time - t0) / 8), 16'(e));
  endtask : period
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // ====================
  // clock, watchdog, tests
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    #480000;
    num_errors++;
    summarize;
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc(7'h6E, 8'h0A);
    rdc(7'h6F, 8'h3D);
    rdc(7'h7F, 8'h00);
    for (n = 0; n < 4; n++)
    begin
      wr(7'h71, 8'(n));
      repeat (2) @(posedge mclk);
      #1 chk(16'({mod_type, mod_ook_en, mod_fsk_en, mod_gauss_en}),
        16'({n[1:0], n == 1, n[1], n == 3}));
    end
    wr(7'h71, 8'hC3);
    repeat (2) @(posedge mclk);
    #1 chk(16'({mod_type, mod_gauss_en}), 16'h0007);
    $display("modulation test done");
    @(posedge mclk) tx_on <= 1'b1;
    wr(7'h73, 8'h55);
    wr(7'h74, 8'h02);
    repeat (2) @(posedge mclk);
    #1 chk({6'h00, synth_correction}, 16'h0255);
    wr(7'h58, 8'hC0);
    wr(7'h70, 8'h00);
    wr(7'h6E, 8'h40);
    wr(7'h6F, 8'h00);
    period(500);
    wr(7'h70, 8'h20);
    wr(7'h6E, 8'h80);
    period(8000);
    @(posedge mclk) tx_on <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(16'(tx_bit_clk), 16'h0000);
    $display("transmit test done");
    wr(7'h1D, 8'h40);
    wr(7'h08, 8'h10);
    @(posedge mclk) rx_on <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk({6'h00, synth_correction}, 16'h0000);
    chk(16'(stay_in_rx), 16'h0001);
    @(posedge mclk) go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    repeat (100) @(posedge mclk);
    #1 chk({6'h00, synth_correction}, 16'h0000);
    @(posedge pend);
    @(posedge mclk) rx_on <= 1'b0;
    wr(7'h2A, 8'hFF);
    wr(7'h1D, 8'h41);
    @(posedge mclk) rx_on <= 1'b1;
    @(posedge mclk) go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    @(posedge pre);
    repeat (3) @(posedge mclk);
    #1 held = synth_correction;
    chk({6'h00, held}, 16'h0050);
    repeat (100) @(posedge mclk);
    #1 chk({6'h00, synth_correction}, {6'h00, held});
    rdc(afc_rate_pkg::afc_read_addr, held[9:2]);
    @(posedge pend);
    repeat (3) @(posedge mclk);
    #1 chk({6'h00, synth_correction}, 16'h0000);
    wr(7'h1D, 8'h01);
    repeat (3) @(posedge mclk);
    #1 chk({6'h00, synth_correction}, 16'h0255);
    $display("receive test done");
    summarize;
  end
endmodule : tb
